// >>> design/mss_pkg.sv
// Constants, register map and types of the multi-step speed sequencer.
// Summary of operation
// - Mode 0: run all sixteen sections once, stop, wait for a new run command.
// - Mode 1: after one pass keep the last section's frequency and direction.
// - Mode 2: restart at section 0 after each pass until a stop command.
// - Retention off: progress is lost at power-down; the next run starts at section 0.
// - Section speeds span -100.0 to 100.0 percent; full scale is the maximum frequency.
// - Section times span 0.0 to 6553.5 in tenths; a unit bit picks seconds or minutes.
// - The sign of a section speed sets the direction; negative means reverse.
// - Multi-step mode reads four terminals as a binary speed number 0 to 15.
// - Multi-step speeds are continuously settable between minus and plus maximum.
// - Multi-step start and stop follow the selected run source, not the terminals.
package mss_pkg;

  // Clock and section timing base.
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TENTH_SEC_NS = 100_000_000;
  localparam int unsigned TENTH_SEC_CYCLES = (TENTH_SEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] TENTHS_PER_MIN = 6'h3c;

  // Register byte offsets within the slave window.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MAXF = 8'h0c;
  localparam logic [7:0] OFS_FREQ = 8'h10;
  localparam logic [1:0] OFS_TABLE_HI = 2'h1;

  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RETAIN_BIT = 2;
  localparam int CTRL_UNIT_BIT = 3;
  localparam int CTRL_SRC_BIT = 4;
  localparam int CTRL_MSTEP_BIT = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // Command register fields.
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;

  // Run modes.
  localparam logic [1:0] MODE_ONCE = 2'h0;
  localparam logic [1:0] MODE_HOLD = 2'h1;
  localparam logic [1:0] MODE_CYCLE = 2'h2;

  // Speed scale in tenths of a percent, and reset values.
  localparam logic signed [15:0] SPEED_FULL = 16'sh03e8;
  localparam logic [15:0] MAXF_RST = 16'h1388;
  localparam logic [31:0] SECTION_RST = 32'h0000_0000;
  localparam logic [3:0] LAST_SECTION = 4'hf;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_HOLD,
    ST_MSTEP,
    ST_PWRDN
  } mss_state_e;

endpackage : mss_pkg

// >>> design/mss_tick.sv
// Tenth-of-second or tenth-of-minute tick generator for section timing.
`timescale 1ns/100ps
module mss_tick import mss_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TENTH_SEC_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic unit_min,
  output logic tick
);

  typedef struct packed {
    logic [31:0] cyc;
    logic [5:0] sub;
    logic tick;
  } mss_tick_s;

  mss_tick_s s_r;
  mss_tick_s s_nxt;

  // The counters restart whenever timing is off, so a section starts on a fresh tenth.
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!enable) begin
      s_nxt.cyc = 32'h0;
      s_nxt.sub = 6'h0;
    end else if (s_r.cyc == TICK_CYCLES[31:0] - 32'h1) begin
      s_nxt.cyc = 32'h0;
      if (!unit_min || s_r.sub == TENTHS_PER_MIN - 6'h1) begin
        s_nxt.sub = 6'h0;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.sub = s_r.sub + 6'h1;
      end
    end else begin
      s_nxt.cyc = s_r.cyc + 32'h1;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule : mss_tick

// >>> design/mss_seq.sv
// Multi-step speed sequencer with AHB-Lite register slave.
`timescale 1ns/100ps
module mss_seq import mss_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TENTH_SEC_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic run_term,
  input wire logic [3:0] ms_term,
  input wire logic power_fail,
  output logic [15:0] freq_ref,
  output logic freq_rev,
  output logic running
);

  typedef struct packed {
    logic [15:0][31:0] tbl;
    logic [5:0] ctrl;
    logic [15:0] maxf;
    logic sw_run;
    logic wr_pend;
    logic [7:0] wr_ofs;
    logic [31:0] rdata;
    logic [2:0] run_s;
    logic run_q;
    logic [2:0][3:0] ms_s;
    logic [3:0] ms_q;
    logic [2:0] pf_s;
    logic pf_q;
    logic run_prev;
    mss_state_e st;
    logic [3:0] idx;
    logic [15:0] elapsed;
    logic done;
    logic [3:0] sv_idx;
    logic [15:0] sv_elapsed;
    logic sv_hold;
    logic sv_valid;
    logic [15:0] freq;
    logic rev;
  } mss_seq_s;

  mss_seq_s s_r;
  mss_seq_s s_nxt;
  logic tick;
  logic [1:0] mode;
  logic retain;
  logic run_lvl;
  logic run_rise;
  logic [15:0] sec_time;
  logic sec_done;
  logic last_fin;
  logic [3:0] act_idx;
  logic [15:0] act_spd;
  logic [9:0] act_mag;
  logic [25:0] prod;
  logic drive_on;
  logic ms_sign;

  // Section tick base; only counts while a timed section runs.
  mss_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) mss_tick_inst (
    .clk(clk),
    .rst(rst),
    .enable(s_r.st == ST_RUN),
    .unit_min(s_r.ctrl[CTRL_UNIT_BIT]),
    .tick(tick)
  );

  // Decoded settings and the run command from the selected source.
  assign mode = s_r.ctrl[CTRL_MODE_LSB +: 2];
  assign retain = s_r.ctrl[CTRL_RETAIN_BIT];
  assign run_lvl = s_r.ctrl[CTRL_SRC_BIT] ? s_r.run_q : s_r.sw_run;
  assign run_rise = run_lvl && !s_r.run_prev;

  // A zero time skips the section at once rather than stalling the sequence.
  assign sec_time = s_r.tbl[s_r.idx][31:16];
  assign sec_done = (sec_time == 16'h0) || (tick && (s_r.elapsed + 16'h1 >= sec_time));
  assign last_fin = (s_r.st == ST_RUN) && run_lvl && !s_r.pf_q && sec_done &&
                    (s_r.idx == LAST_SECTION);

  // Speed of the active section and its scaling to the maximum frequency.
  assign act_idx = (s_r.st == ST_MSTEP) ? s_r.ms_q : s_r.idx;
  assign act_spd = s_r.tbl[act_idx][15:0];
  assign act_mag = act_spd[15] ? 10'(16'h0 - act_spd) : act_spd[9:0];
  assign prod = 26'(act_mag) * 26'(s_r.maxf);
  assign drive_on = (s_r.st == ST_RUN) || (s_r.st == ST_HOLD) || (s_r.st == ST_MSTEP);

  // Sign of the speed that the terminals pick, read straight from the table.
  // Only the checks use it, so a broken index path in the drive logic shows up.
  assign ms_sign = s_r.tbl[s_r.ms_q][15];

  // Bus, synchronisers, register writes and the sequencer, all as one next state.
  always_comb begin
    logic [31:0] rv;
    logic signed [15:0] spd_in;
    rv = 32'h0;
    spd_in = $signed(hwdata[15:0]);
    s_nxt = s_r;

    // Pin inputs: three stages, a change is taken once stages two and three agree.
    s_nxt.run_s = {s_r.run_s[1:0], run_term};
    if (s_r.run_s[1] == s_r.run_s[2]) begin
      s_nxt.run_q = s_r.run_s[2];
    end
    s_nxt.ms_s = {s_r.ms_s[1:0], ms_term};
    if (s_r.ms_s[1] == s_r.ms_s[2]) begin
      s_nxt.ms_q = s_r.ms_s[2];
    end
    s_nxt.pf_s = {s_r.pf_s[1:0], power_fail};
    if (s_r.pf_s[1] == s_r.pf_s[2]) begin
      s_nxt.pf_q = s_r.pf_s[2];
    end

    // Read mux; unmapped offsets read as zero.
    if (haddr[7:6] == OFS_TABLE_HI) begin
      rv = s_r.tbl[haddr[5:2]];
    end else begin
      case (haddr[7:0])
        OFS_CTRL: rv = {26'h0, s_r.ctrl};
        OFS_CMD: rv = {31'h0, s_r.sw_run};
        OFS_STATUS: rv = {23'h0, s_r.st == ST_PWRDN, s_r.sv_valid, s_r.done, s_r.rev,
                          drive_on, act_idx};
        OFS_MAXF: rv = {16'h0, s_r.maxf};
        OFS_FREQ: rv = {16'h0, s_r.freq};
        default: rv = 32'h0;
      endcase
    end

    // Address phase: the slave never waits, so read data is ready in the data phase.
    s_nxt.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      s_nxt.wr_pend = hwrite && (hsize == HSIZE_WORD);
      s_nxt.wr_ofs = haddr[7:0];
      s_nxt.rdata = hwrite ? 32'h0 : rv;
    end

    // Data phase writes; speeds beyond full scale are clamped on entry.
    if (s_r.wr_pend) begin
      if (s_r.wr_ofs[7:6] == OFS_TABLE_HI) begin
        if (spd_in > SPEED_FULL) begin
          spd_in = SPEED_FULL;
        end else if (spd_in < -SPEED_FULL) begin
          spd_in = -SPEED_FULL;
        end
        s_nxt.tbl[s_r.wr_ofs[5:2]] = {hwdata[31:16], spd_in};
      end else begin
        case (s_r.wr_ofs)
          OFS_CTRL: s_nxt.ctrl = hwdata[5:0];
          OFS_CMD: begin
            if (hwdata[CMD_STOP_BIT]) begin
              s_nxt.sw_run = 1'b0;
            end else if (hwdata[CMD_START_BIT]) begin
              s_nxt.sw_run = 1'b1;
            end
          end
          OFS_MAXF: s_nxt.maxf = hwdata[15:0];
          default: s_nxt.sw_run = s_nxt.sw_run;
        endcase
      end
    end

    s_nxt.run_prev = run_lvl;

    // Power-down takes priority over everything the sequencer would do.
    if (s_r.pf_q && s_r.st != ST_PWRDN) begin
      s_nxt.st = ST_PWRDN;
      if (retain && (s_r.st == ST_RUN || s_r.st == ST_HOLD)) begin
        s_nxt.sv_idx = s_r.idx;
        s_nxt.sv_elapsed = s_r.elapsed;
        s_nxt.sv_hold = (s_r.st == ST_HOLD);
        s_nxt.sv_valid = 1'b1;
      end else if (!retain) begin
        s_nxt.sv_valid = 1'b0;
      end
    end else begin
      unique case (s_r.st)
        ST_IDLE: begin
          if (run_rise) begin
            s_nxt.done = 1'b0;
            if (s_r.ctrl[CTRL_MSTEP_BIT]) begin
              s_nxt.st = ST_MSTEP;
            end else if (retain && s_r.sv_valid) begin
              s_nxt.idx = s_r.sv_idx;
              s_nxt.elapsed = s_r.sv_elapsed;
              s_nxt.st = s_r.sv_hold ? ST_HOLD : ST_RUN;
              s_nxt.sv_valid = 1'b0;
            end else begin
              s_nxt.idx = 4'h0;
              s_nxt.elapsed = 16'h0;
              s_nxt.st = ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (!run_lvl) begin
            s_nxt.st = ST_IDLE;
          end else if (sec_done) begin
            s_nxt.elapsed = 16'h0;
            if (s_r.idx != LAST_SECTION) begin
              s_nxt.idx = s_r.idx + 4'h1;
            end else if (mode == MODE_HOLD) begin
              s_nxt.st = ST_HOLD;
            end else if (mode == MODE_CYCLE) begin
              s_nxt.idx = 4'h0;
            end else begin
              // Mode 3 is not defined and behaves as a single pass.
              s_nxt.st = ST_IDLE;
              s_nxt.done = 1'b1;
              s_nxt.sw_run = 1'b0;
            end
          end else if (tick) begin
            s_nxt.elapsed = s_r.elapsed + 16'h1;
          end
        end
        ST_HOLD: begin
          if (!run_lvl) begin
            s_nxt.st = ST_IDLE;
          end
        end
        ST_MSTEP: begin
          if (!run_lvl) begin
            s_nxt.st = ST_IDLE;
          end
        end
        ST_PWRDN: begin
          // A run level still present at restore counts as a fresh command.
          if (!s_r.pf_q) begin
            s_nxt.st = ST_IDLE;
            s_nxt.run_prev = 1'b0;
          end
        end
      endcase
    end

    // Output reference, registered; zero whenever the drive is not commanded.
    if (drive_on) begin
      s_nxt.freq = 16'(prod / 26'd1000);
      s_nxt.rev = act_spd[15];
    end else begin
      s_nxt.freq = 16'h0;
      s_nxt.rev = 1'b0;
    end
  end

  // State register; every bit has a defined value after reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.tbl <= {16{SECTION_RST}};
      s_r.ctrl <= CTRL_RST;
      s_r.maxf <= MAXF_RST;
      s_r.st <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Bus and drive outputs; the slave is zero-wait and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;
  assign freq_ref = s_r.freq;
  assign freq_rev = s_r.rev;
  assign running = (s_r.st == ST_RUN) || (s_r.st == ST_HOLD) || (s_r.st == ST_MSTEP);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Every check below watches registered state, so all but AST_SPEED_RANGE build in one edge of latency.
  // The frequency bound holds only because table speeds are clamped on entry.
  // A terminal code may change on any edge, so the direction check looks one edge back.
  AST_ONCE_STOPS: assert property (last_fin && mode == MODE_ONCE |=>
    s_r.st == ST_IDLE && s_r.done && !s_r.sw_run ##1 s_r.freq == 16'h0)
    else $error("single pass did not stop after the last section");

  AST_HOLD_LAST: assert property (s_r.st == ST_HOLD && run_lvl && !s_r.pf_q |=>
    s_r.st == ST_HOLD && s_r.idx == LAST_SECTION)
    else $error("hold mode left the last section while running");

  AST_CYCLE_WRAP: assert property (last_fin && mode == MODE_CYCLE |=>
    s_r.st == ST_RUN && s_r.idx == 4'h0 && s_r.elapsed == 16'h0)
    else $error("cyclic mode did not wrap to section zero");

  AST_NO_RETAIN: assert property (s_r.pf_q && !retain && s_r.st != ST_PWRDN |=>
    !s_r.sv_valid && s_r.st == ST_PWRDN)
    else $error("progress kept with retention off");

  AST_RETAIN_SAVE: assert property (s_r.pf_q && retain && s_r.st == ST_RUN |=>
    s_r.sv_valid && s_r.sv_idx == $past(s_r.idx) && s_r.sv_elapsed == $past(s_r.elapsed))
    else $error("section progress not saved at power-down");

  AST_SPEED_RANGE: assert property ($signed(act_spd) <= SPEED_FULL &&
    $signed(act_spd) >= -SPEED_FULL)
    else $error("section speed outside full scale");

  AST_DIR_SIGN: assert property (drive_on && act_spd[15] |=> s_r.rev)
    else $error("negative speed did not command reverse");

  AST_MSTEP_SEL: assert property (s_r.st == ST_MSTEP |-> act_idx == s_r.ms_q ##1
    s_r.rev == $past(ms_sign))
    else $error("multi-step terminals did not select the speed");

  AST_MSTEP_STOP: assert property (s_r.st == ST_MSTEP && !run_lvl && !s_r.pf_q |=>
    s_r.st == ST_IDLE ##1 !running)
    else $error("multi-step did not stop with the run source");

  AST_START_ZERO: assert property (s_r.st == ST_IDLE && run_rise && !s_r.pf_q &&
    !s_r.ctrl[CTRL_MSTEP_BIT] && !(retain && s_r.sv_valid) |=>
    s_r.st == ST_RUN && s_r.idx == 4'h0 && s_r.elapsed == 16'h0)
    else $error("new run did not start at section zero");

  // A finished section hands over to the next one with a fresh elapsed count.
  AST_SEC_ADVANCE: assert property (sec_done && s_r.st == ST_RUN && run_lvl &&
    !s_r.pf_q && s_r.idx != LAST_SECTION |=>
    s_r.st == ST_RUN && s_r.idx == $past(s_r.idx) + 4'h1 && s_r.elapsed == 16'h0)
    else $error("sequence did not advance to the next section");

  AST_FREQ_SCALE: assert property (drive_on |=> s_r.freq <= $past(s_r.maxf))
    else $error("frequency reference above the maximum frequency");

  // Power-down must silence the drive whatever state it interrupted.
  AST_PWRDN_ZERO: assert property (s_r.st == ST_PWRDN |=> s_r.freq == 16'h0 && !s_r.rev)
    else $error("drive still commanded during power-down");

  COV_ONCE_DONE: cover property (last_fin && mode == MODE_ONCE);
  COV_CYCLE_WRAP: cover property (last_fin && mode == MODE_CYCLE);
  COV_RESUME: cover property (s_r.st == ST_IDLE && run_rise && retain && s_r.sv_valid);
  COV_MSTEP_REV: cover property (s_r.st == ST_MSTEP && s_r.rev);
  COV_HOLD: cover property (s_r.st == ST_HOLD && run_lvl);

endmodule : mss_seq

// >>> verif/mss_term_model.sv
// Model of the run terminal, the multi-step terminals and the power-fail line.
`timescale 1ns/100ps
module mss_term_model (
  input wire logic clk,
  input wire logic run_req,
  input wire logic [3:0] code_req,
  input wire logic pfail_req,
  output logic run_term,
  output logic [3:0] ms_term,
  output logic power_fail
);
  // Lines start low so the synchronisers see a defined level from time zero.
  initial begin
    run_term = 1'b0;
    ms_term = 4'h0;
    power_fail = 1'b0;
  end

  // Levels move just after an edge, as a switch bank would, with no glitches.
  always @(posedge clk) begin
    run_term <= run_req; // Run level from the external source.
    ms_term <= code_req; // Binary speed number on four terminals.
    power_fail <= pfail_req; // Supply monitor level.
  end
endmodule : mss_term_model

// >>> verif/mss_seq_tb_top.sv
// Self-checking testbench of the multi-step speed sequencer.
`timescale 1ns/100ps
module mss_seq_tb_top import mss_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic run_req = 1'b0;
  logic pfail_req = 1'b0;
  logic [3:0] code_req = 4'h0;
  logic hreadyout, hresp, freq_rev, running, run_term, power_fail;
  logic [31:0] hrdata, rd;
  logic [3:0] ms_term;
  logic [15:0] freq_ref;
  int bad_count = 0;
  int total_checks = 0;

  // An 8 ns clock.
  always #4 clk = ~clk;

  // A short tick keeps each tenth of a second four cycles long.
  mss_seq #(.TICK_CYCLES(4)) mss_seq_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .run_term(run_term),
    .ms_term(ms_term), .power_fail(power_fail), .freq_ref(freq_ref), .freq_rev(freq_rev),
    .running(running));

  mss_term_model mss_term_model_inst (.clk(clk), .run_req(run_req), .code_req(code_req),
    .pfail_req(pfail_req), .run_term(run_term), .ms_term(ms_term), .power_fail(power_fail));

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // One single word transfer; read data lands in rd at the end of the data phase.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    hsize <= HSIZE_WORD;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus

  task wait_run(input logic lvl);
    int n;
    n = 0;
    while (running !== lvl && n < 400) begin
      @(posedge clk);
      n++;
    end
    check(running, lvl, "running level");
  endtask : wait_run

  // Polls the status word until the wanted section is active.
  task wait_sec(input logic [3:0] s);
    int n;
    n = 0;
    bus(1'b0, OFS_STATUS, 32'h0);
    while (rd[3:0] !== s && n < 400) begin
      bus(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    check(rd[3:0], s, "active section");
  endtask : wait_sec

  // Section word: odd sections run reverse, magnitude grows by 50 per section.
  function automatic logic [31:0] sec(input int i, input logic [15:0] t);
    logic [15:0] m;
    m = 16'(100 + 50 * i);
    return {t, i[0] ? -m : m};
  endfunction : sec

  task start_seq(input logic [31:0] ctrl);
    bus(1'b1, OFS_CTRL, ctrl);
    bus(1'b1, OFS_CMD, 32'h1);
    wait_run(1'b1);
  endtask : start_seq

  task stop_seq();
    bus(1'b1, OFS_CMD, 32'h2);
    wait_run(1'b0);
    repeat (2) @(posedge clk);
    check(freq_ref, 32'h0, "freq after stop");
  endtask : stop_seq

  task t_reset();
    bus(1'b0, OFS_CTRL, 32'h0);
    check(rd, 32'h0, "ctrl reset");
    bus(1'b0, OFS_MAXF, 32'h0);
    check(rd, {16'h0, MAXF_RST}, "maxf reset");
    bus(1'b0, 8'h40, 32'h0);
    check(rd, SECTION_RST, "section reset");
    bus(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0, "unmapped read");
    check(running, 1'b0, "idle after reset");
    check(hresp, 1'b0, "bus response okay");
    check(hreadyout, 1'b1, "bus ready");
  endtask : t_reset

  // Out-of-range speed is clamped; the longest time is kept whole.
  task t_table();
    bus(1'b1, 8'h7c, {16'hffff, 16'hf830});
    bus(1'b0, 8'h7c, 32'h0);
    check(rd, {16'hffff, 16'hfc18}, "clamp and max time");
    bus(1'b1, OFS_MAXF, 32'h3e8);
    for (int i = 0; i < 16; i++) bus(1'b1, 8'h40 + 8'(4 * i), sec(i, 16'h2));
  endtask : t_table

  task t_once();
    int n;
    start_seq({30'h0, MODE_ONCE});
    repeat (2) @(posedge clk);
    check(freq_ref, 32'd100, "section 0 freq");
    check(freq_rev, 1'b0, "section 0 dir");
    n = 0;
    while (freq_rev !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    check(freq_ref, 32'd150, "section 1 freq");
    check(freq_rev, 1'b1, "section 1 dir");
    wait_run(1'b0);
    bus(1'b0, OFS_STATUS, 32'h0);
    check(rd[6], 1'b1, "pass done");
    repeat (40) @(posedge clk);
    check(running, 1'b0, "no restart");
    bus(1'b0, OFS_CMD, 32'h0);
    check(rd[0], 1'b0, "run request cleared");
  endtask : t_once

  task t_hold();
    start_seq({30'h0, MODE_HOLD});
    wait_sec(4'hf);
    repeat (40) @(posedge clk);
    check(running, 1'b1, "hold running");
    check(freq_ref, 32'd850, "hold freq");
    check(freq_rev, 1'b1, "hold dir");
    bus(1'b0, OFS_STATUS, 32'h0);
    check(rd[8:0], 9'h03f, "hold status");
    bus(1'b0, OFS_FREQ, 32'h0);
    check(rd, 32'd850, "freq register");
    stop_seq();
  endtask : t_hold

  // Minute unit: one tenth takes sixty base ticks of four cycles, two tenths per section.
  task t_unit();
    start_seq({28'h0, 1'b1, 1'b0, MODE_HOLD});
    repeat (8 * int'(TENTHS_PER_MIN) - 40) @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h0);
    check(rd[3:0], 4'h0, "minute section still 0");
    repeat (60) @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h0);
    check(rd[3:0], 4'h1, "minute section advanced");
    stop_seq();
  endtask : t_unit

  task t_cycle();
    start_seq({30'h0, MODE_CYCLE});
    wait_sec(4'hf);
    wait_sec(4'h0);
    check(running, 1'b1, "cyclic wrap");
    wait_sec(4'h1);
    stop_seq();
  endtask : t_cycle

  // Terminals pick the speed; only the run terminal starts and stops.
  task t_mstep();
    bus(1'b1, OFS_CTRL, 32'h30);
    code_req <= 4'h5;
    repeat (10) @(posedge clk);
    check(running, 1'b0, "code alone no start");
    run_req <= 1'b1;
    wait_run(1'b1);
    for (int c = 0; c < 16; c++) begin
      code_req <= 4'(c);
      repeat (10) @(posedge clk);
      check(freq_ref, 32'(100 + 50 * c), "step freq");
      check(freq_rev, c[0], "step dir");
    end
    run_req <= 1'b0;
    wait_run(1'b0);
  endtask : t_mstep

  // Power loss in section 3, without and then with retention.
  task t_power();
    bus(1'b1, 8'h4c, sec(3, 16'd20));
    for (int r = 0; r < 2; r++) begin
      start_seq({29'h0, r[0], MODE_ONCE});
      wait_sec(4'h3);
      pfail_req <= 1'b1;
      repeat (10) @(posedge clk);
      check(freq_ref, 32'h0, "freq at power loss");
      bus(1'b0, OFS_STATUS, 32'h0);
      check(rd[8:7], {1'b1, r[0]}, "saved progress");
      bus(1'b1, OFS_CMD, 32'h2);
      pfail_req <= 1'b0;
      repeat (10) @(posedge clk);
      bus(1'b1, OFS_CMD, 32'h1);
      wait_run(1'b1);
      repeat (2) @(posedge clk);
      check(freq_ref, r[0] ? 32'd250 : 32'd100, "resume point");
      stop_seq();
    end
  endtask : t_power

  task tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // The tests need under two thousand cycles; fifteen times that means a hang.
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_table();
    t_once();
    t_hold();
    t_cycle();
    t_unit();
    t_mstep();
    t_power();
    tally_and_finish();
  end
endmodule : mss_seq_tb_top
